// >>> hdl/mic_intc.sv
// interrupt controller: flags, enables, priority, vector call, wake.
// assumes a classic wishbone master, one-cycle overflow pulses from the
// timers and time base, and a core that obeys irq_call_q at once.
`timescale 1ns/1ps

// How it works
// - primary register: global, ext, t0, t1 enables bits 0-3; flags 4-6
// - secondary register: time-base flag at bit 4, enable at bit 0
// - timer overflow sets its flag; taken only with global and own enable
// - timer call forced only when stack has room and interrupt enabled
// - servicing a timer clears its flag and the global enable
// - time-base overflow sets its flag; taken with global and own enable
// - time-base call only when enabled and stack has room
// - servicing time base clears its flag and the global enable
// - set flag stays until serviced or cleared by software write
// - any pending source wakes the core from idle or sleep
// - interrupt entry pushes only the program counter
// - priority ext, t0, t1, time base; vectors 04, 08, 0c, 10
// - call follows 2 or 3 instruction cycles; 3 when waking
// - two-bit edge select: off, rising, falling or both edges
// - stack full blocks acknowledgement; flag stays recorded
module mic_intc
	import mic_pkg::*;
#(
	parameter int ICYC_CLKS = MIC_ICYC_CLKS
)(
	// clock and reset
	input  wire logic                       mclk,
	input  wire logic                       rst_b,
	// wishbone slave
	input  wire logic                       wb_cyc_i,
	input  wire logic                       wb_stb_i,
	input  wire logic                       wb_we_i,
	input  wire logic [mic_pkg::MIC_ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]                 wb_sel_i,
	input  wire logic [31:0]                wb_dat_i,
	output logic                            wb_ack_o,
	output logic [31:0]                     wb_dat_o,
	// event sources
	input  wire logic                       ext_irq_pin,
	input  wire logic                       timer0_ovf,
	input  wire logic                       timer1_ovf,
	input  wire logic                       timebase_ovf,
	// core handshake
	input  wire logic                       stack_full,
	input  wire logic                       core_asleep,
	output logic                            irq_call_q,
	output logic                            push_pc_q,
	output logic [7:0]                      irq_vector_q,
	output logic                            wake_q
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	logic                  ack_q;
	logic [31:0]           dat_q;
	logic                  bus_req;
	logic                  bus_wr;
	logic [7:0]            rd_byte;
	logic                  gie_q;
	logic [MIC_NSRC-1:0]   en_q;
	logic [MIC_NSRC-1:0]   flag_q;
	logic [MIC_NSRC-1:0]   set_ev;
	logic [MIC_NSRC-1:0]   wr_hit;
	logic [MIC_NSRC-1:0]   wr_val;
	logic [MIC_NSRC-1:0]   svc_clr;
	logic [MIC_NSRC-1:0]   pend;
	logic [1:0]            edge_sel_q;
	logic                  ext_pulse;
	logic [7:0]            div_q;
	logic                  tick;
	mic_state_t            state_q;
	mic_src_t              src_q;
	mic_src_t              pick;
	logic [1:0]            lat_q;
	logic                  accept;
	logic                  wr_prim;
	logic                  wr_sec;
	logic                  wr_sys;

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	// ****************************************************************
	// wishbone slave
	// ****************************************************************
	// writes land on the edge that raises ack; ack lasts one cycle
	assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
	assign bus_wr  = bus_req & wb_we_i & wb_sel_i[0];
	assign wr_prim = bus_wr & (wb_adr_i == MIC_OFS_PRIMARY);
	assign wr_sec  = bus_wr & (wb_adr_i == MIC_OFS_SECOND);
	assign wr_sys  = bus_wr & (wb_adr_i == MIC_OFS_SYSCTL);

	always_comb begin
		rd_byte = MIC_REG_RESET;
		unique case (wb_adr_i)
			MIC_OFS_PRIMARY: begin
				rd_byte[MIC_B_GIE]      = gie_q;
				rd_byte[MIC_B_EXT_EN]   = en_q[MIC_SRC_EXT];
				rd_byte[MIC_B_T0_EN]    = en_q[MIC_SRC_T0];
				rd_byte[MIC_B_T1_EN]    = en_q[MIC_SRC_T1];
				rd_byte[MIC_B_EXT_FLAG] = flag_q[MIC_SRC_EXT];
				rd_byte[MIC_B_T0_FLAG]  = flag_q[MIC_SRC_T0];
				rd_byte[MIC_B_T1_FLAG]  = flag_q[MIC_SRC_T1];
			end
			MIC_OFS_SECOND: begin
				rd_byte[MIC_B_TB_EN]   = en_q[MIC_SRC_TB];
				rd_byte[MIC_B_TB_FLAG] = flag_q[MIC_SRC_TB];
			end
			MIC_OFS_SYSCTL: begin
				rd_byte[MIC_B_EDGE_HI:MIC_B_EDGE_LO] = edge_sel_q;
			end
			MIC_OFS_STATUS: begin
				rd_byte[MIC_B_ST_BUSY]                   = state_q;
				rd_byte[MIC_B_ST_FULL]                   = stack_full;
				rd_byte[MIC_B_ST_SRC_LO+1:MIC_B_ST_SRC_LO] = src_q;
				rd_byte[MIC_B_ST_WAKE]                   = wake_q;
			end
			default: rd_byte = MIC_REG_RESET;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			ack_q <= 1'b0;
			dat_q <= {MIC_UPPER_ZERO, MIC_REG_RESET};
		end else begin
			ack_q <= bus_req;
			if (bus_req) begin
				dat_q <= {MIC_UPPER_ZERO, rd_byte};
			end
		end
	end

	// ****************************************************************
	// edge select and external edge detection
	// ****************************************************************
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			edge_sel_q <= MIC_EDGE_OFF;
		end else if (wr_sys) begin
			edge_sel_q <= wb_dat_i[MIC_B_EDGE_HI:MIC_B_EDGE_LO];
		end
	end

	mic_edge_detect u_edge (
		.mclk         (mclk),
		.rst_b        (rst_b),
		.pin_i        (ext_irq_pin),
		.edge_sel     (mic_edge_t'(edge_sel_q)),
		.edge_pulse_q (ext_pulse)
	);

	// ****************************************************************
	// instruction cycle divider
	// ****************************************************************
	// one evaluation per instruction cycle keeps calls from stacking up
	assign tick = (div_q == 8'(ICYC_CLKS - 1));

	always_ff @(posedge mclk) begin
		if (!rst_b || tick) begin
			div_q <= 8'h00;
		end else begin
			div_q <= div_q + 8'h01;
		end
	end

	// ****************************************************************
	// enables
	// ****************************************************************
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			en_q <= '0;
		end else begin
			if (wr_prim) begin
				en_q[MIC_SRC_EXT] <= wb_dat_i[MIC_B_EXT_EN];
				en_q[MIC_SRC_T0]  <= wb_dat_i[MIC_B_T0_EN];
				en_q[MIC_SRC_T1]  <= wb_dat_i[MIC_B_T1_EN];
			end
			if (wr_sec) begin
				en_q[MIC_SRC_TB] <= wb_dat_i[MIC_B_TB_EN];
			end
		end
	end

	// servicing beats a software set of the global enable
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			gie_q <= 1'b0;
		end else if (accept) begin
			gie_q <= 1'b0;
		end else if (wr_prim) begin
			gie_q <= wb_dat_i[MIC_B_GIE];
		end
	end

	// ****************************************************************
	// request flags
	// ****************************************************************
	assign set_ev = {timebase_ovf, timer1_ovf, timer0_ovf, ext_pulse};
	assign wr_hit = {wr_sec, wr_prim, wr_prim, wr_prim};
	assign wr_val = {wb_dat_i[MIC_B_TB_FLAG], wb_dat_i[MIC_B_T1_FLAG],
		wb_dat_i[MIC_B_T0_FLAG], wb_dat_i[MIC_B_EXT_FLAG]};

	genvar gi;
	generate
		for (gi = 0; gi < MIC_NSRC; gi++) begin : g_flag
			// cleared by the very accept that picked this source
			assign svc_clr[gi] = accept & (pick == mic_src_t'(gi));
			// a new event in the clearing cycle wins over the clear
			always_ff @(posedge mclk) begin
				if (!rst_b) begin
					flag_q[gi] <= 1'b0;
				end else begin
					flag_q[gi] <= ((wr_hit[gi] ? wr_val[gi] : flag_q[gi])
						& ~svc_clr[gi]) | set_ev[gi];
				end
			end
		end
	endgenerate

	// ****************************************************************
	// priority and acceptance
	// ****************************************************************
	assign pend = flag_q & en_q;

	always_comb begin
		if (pend[MIC_SRC_EXT]) begin
			pick = MIC_SRC_EXT;
		end else if (pend[MIC_SRC_T0]) begin
			pick = MIC_SRC_T0;
		end else if (pend[MIC_SRC_T1]) begin
			pick = MIC_SRC_T1;
		end else begin
			pick = MIC_SRC_TB;
		end
	end

	// full stack holds the request back; the flag simply stays set
	assign accept = tick & (state_q == MIC_ST_IDLE) & gie_q & (|pend)
		& ~stack_full;

	// ****************************************************************
	// call sequencer
	// ****************************************************************
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			state_q    <= MIC_ST_IDLE;
			src_q      <= MIC_SRC_EXT;
			lat_q      <= 2'h0;
			irq_call_q <= 1'b0;
			push_pc_q  <= 1'b0;
		end else begin
			irq_call_q <= 1'b0;
			push_pc_q  <= 1'b0;
			unique case (state_q)
				MIC_ST_IDLE: begin
					if (accept) begin
						state_q <= MIC_ST_WAIT;
						src_q   <= pick;
						// waking costs one extra instruction cycle
						lat_q   <= core_asleep ? MIC_LAT_WAKE
							: MIC_LAT_AWAKE;
					end
				end
				MIC_ST_WAIT: begin
					if (tick) begin
						if (lat_q == 2'h1) begin
							state_q    <= MIC_ST_IDLE;
							irq_call_q <= 1'b1;
							push_pc_q  <= 1'b1;
						end
						lat_q <= lat_q - 2'h1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			irq_vector_q <= MIC_VEC_EXT;
		end else begin
			unique case (src_q)
				MIC_SRC_EXT: irq_vector_q <= MIC_VEC_EXT;
				MIC_SRC_T0:  irq_vector_q <= MIC_VEC_T0;
				MIC_SRC_T1:  irq_vector_q <= MIC_VEC_T1;
				MIC_SRC_TB:  irq_vector_q <= MIC_VEC_TB;
			endcase
		end
	end

	// ****************************************************************
	// wake request
	// ****************************************************************
	// wake ignores the global enable so a masked core still wakes
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			wake_q <= 1'b0;
		end else begin
			wake_q <= |pend;
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	sequence s_quiet8;
		!irq_call_q [*8];
	endsequence

	property p_upper_zero;
		@(posedge mclk) disable iff (!rst_b)
		(bus_req && !wb_we_i && wb_adr_i == MIC_OFS_PRIMARY)
			|=> (dat_q[31:7] == 25'h0);
	endproperty
	a_upper_zero: assert property (p_upper_zero)
		else $error("reserved read bits not zero");

	property p_sec_zero;
		@(posedge mclk) disable iff (!rst_b)
		(bus_req && !wb_we_i && wb_adr_i == MIC_OFS_SECOND)
			|=> (dat_q[7:0] & 8'hee) == 8'h00;
	endproperty
	a_sec_zero: assert property (p_sec_zero)
		else $error("unused secondary bits not zero");

	property p_t0_set;
		@(posedge mclk) disable iff (!rst_b)
		timer0_ovf |=> flag_q[MIC_SRC_T0];
	endproperty
	a_t0_set: assert property (p_t0_set)
		else $error("timer 0 overflow did not set flag");

	property p_tb_set;
		@(posedge mclk) disable iff (!rst_b)
		timebase_ovf |=> flag_q[MIC_SRC_TB];
	endproperty
	a_tb_set: assert property (p_tb_set)
		else $error("time base overflow did not set flag");

	property p_no_take_full;
		@(posedge mclk) disable iff (!rst_b)
		(stack_full || !gie_q) |=> $stable(state_q) || state_q == MIC_ST_IDLE;
	endproperty
	a_no_take_full: assert property (p_no_take_full)
		else $error("request taken while blocked");

	property p_t0_svc;
		@(posedge mclk) disable iff (!rst_b)
		(accept && pick == MIC_SRC_T0 && !timer0_ovf)
			|=> !flag_q[MIC_SRC_T0] && !gie_q;
	endproperty
	a_t0_svc: assert property (p_t0_svc)
		else $error("timer service did not clear flag and enable");

	property p_tb_svc;
		@(posedge mclk) disable iff (!rst_b)
		(accept && pick == MIC_SRC_TB && !timebase_ovf)
			|=> !flag_q[MIC_SRC_TB] && !gie_q;
	endproperty
	a_tb_svc: assert property (p_tb_svc)
		else $error("time base service did not clear flag and enable");

	property p_flag_hold;
		@(posedge mclk) disable iff (!rst_b)
		(flag_q[MIC_SRC_T1] && !accept && !wr_prim) |=> flag_q[MIC_SRC_T1];
	endproperty
	a_flag_hold: assert property (p_flag_hold)
		else $error("flag dropped without service or write");

	property p_wake;
		@(posedge mclk) disable iff (!rst_b)
		(|pend) |=> wake_q;
	endproperty
	a_wake: assert property (p_wake)
		else $error("pending source did not wake core");

	property p_push_pc;
		@(posedge mclk) disable iff (!rst_b)
		push_pc_q == irq_call_q;
	endproperty
	a_push_pc: assert property (p_push_pc)
		else $error("push not tied to call");

	property p_ext_first;
		@(posedge mclk) disable iff (!rst_b)
		(accept && pend[MIC_SRC_EXT]) |=> ##8 irq_vector_q == MIC_VEC_EXT;
	endproperty
	a_ext_first: assert property (p_ext_first)
		else $error("external request lost priority");

	property p_lat_awake;
		@(posedge mclk) disable iff (!rst_b)
		(accept && !core_asleep && ICYC_CLKS == 4)
			|=> s_quiet8 ##1 irq_call_q;
	endproperty
	a_lat_awake: assert property (p_lat_awake)
		else $error("awake call latency wrong");

	property p_lat_wake;
		@(posedge mclk) disable iff (!rst_b)
		(accept && core_asleep && ICYC_CLKS == 4)
			|=> s_quiet8 ##1 !irq_call_q [*4] ##1 irq_call_q;
	endproperty
	a_lat_wake: assert property (p_lat_wake)
		else $error("wake call latency wrong");

	property p_single_call;
		@(posedge mclk) disable iff (!rst_b)
		irq_call_q |=> !irq_call_q;
	endproperty
	a_single_call: assert property (p_single_call)
		else $error("more than one call per evaluation");

endmodule : mic_intc

// >>> hdl/mic_pkg.sv
// shared constants of the interrupt controller: register map, field
// positions, reset values, vectors, latencies and enumerations.
// assumes a 32-bit classic wishbone slave port and an 8-bit core.
package mic_pkg;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam int                    MIC_ADR_W       = 4;
	localparam logic [MIC_ADR_W-1:0]  MIC_OFS_PRIMARY = 4'h0;
	localparam logic [MIC_ADR_W-1:0]  MIC_OFS_SECOND  = 4'h4;
	localparam logic [MIC_ADR_W-1:0]  MIC_OFS_SYSCTL  = 4'h8;
	localparam logic [MIC_ADR_W-1:0]  MIC_OFS_STATUS  = 4'hc;
	localparam logic [7:0]            MIC_REG_RESET   = 8'h00;
	localparam logic [23:0]           MIC_UPPER_ZERO  = 24'h000000;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int MIC_B_GIE       = 0;
	localparam int MIC_B_EXT_EN    = 1;
	localparam int MIC_B_T0_EN     = 2;
	localparam int MIC_B_T1_EN     = 3;
	localparam int MIC_B_EXT_FLAG  = 4;
	localparam int MIC_B_T0_FLAG   = 5;
	localparam int MIC_B_T1_FLAG   = 6;
	localparam int MIC_B_TB_EN     = 0;
	localparam int MIC_B_TB_FLAG   = 4;
	localparam int MIC_B_EDGE_LO   = 6;
	localparam int MIC_B_EDGE_HI   = 7;
	localparam int MIC_B_ST_BUSY   = 0;
	localparam int MIC_B_ST_FULL   = 1;
	localparam int MIC_B_ST_SRC_LO = 2;
	localparam int MIC_B_ST_WAKE   = 4;

	// ****************************************************************
	// sources, vectors, timing
	// ****************************************************************
	localparam int         MIC_NSRC      = 4;
	localparam logic [7:0] MIC_VEC_EXT   = 8'h04;
	localparam logic [7:0] MIC_VEC_T0    = 8'h08;
	localparam logic [7:0] MIC_VEC_T1    = 8'h0c;
	localparam logic [7:0] MIC_VEC_TB    = 8'h10;
	localparam int         MIC_ICYC_CLKS = 4;
	localparam logic [1:0] MIC_LAT_AWAKE = 2'h2;
	localparam logic [1:0] MIC_LAT_WAKE  = 2'h3;

	typedef enum logic [1:0] {
		MIC_SRC_EXT = 2'b00,
		MIC_SRC_T0  = 2'b01,
		MIC_SRC_T1  = 2'b10,
		MIC_SRC_TB  = 2'b11
	} mic_src_t;

	typedef enum logic [1:0] {
		MIC_EDGE_OFF  = 2'b00,
		MIC_EDGE_RISE = 2'b01,
		MIC_EDGE_FALL = 2'b10,
		MIC_EDGE_BOTH = 2'b11
	} mic_edge_t;

	typedef enum logic {
		MIC_ST_IDLE = 1'b0,
		MIC_ST_WAIT = 1'b1
	} mic_state_t;

endpackage : mic_pkg

// >>> hdl/mic_edge_detect.sv
// edge detector for the external interrupt input with selectable edge.
// assumes the pin is already synchronous to mclk.
`timescale 1ns/1ps

module mic_edge_detect
	import mic_pkg::*;
(
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             rst_b,
	// pin and selection
	input  wire logic             pin_i,
	input  wire mic_pkg::mic_edge_t edge_sel,
	// detected edge
	output logic                  edge_pulse_q
);

	logic prev_q;
	logic hit;

	always_comb begin
		unique case (edge_sel)
			MIC_EDGE_OFF:  hit = 1'b0;
			MIC_EDGE_RISE: hit = pin_i & ~prev_q;
			MIC_EDGE_FALL: hit = ~pin_i & prev_q;
			MIC_EDGE_BOTH: hit = pin_i ^ prev_q;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			prev_q       <= 1'b0;
			edge_pulse_q <= 1'b0;
		end else begin
			prev_q       <= pin_i;
			edge_pulse_q <= hit;
		end
	end

	property p_rise_edge;
		@(posedge mclk) disable iff (!rst_b)
		(edge_sel == MIC_EDGE_RISE && pin_i && !prev_q) |=> edge_pulse_q;
	endproperty
	a_rise_edge: assert property (p_rise_edge)
		else $error("rising edge not detected");

	property p_off_quiet;
		@(posedge mclk) disable iff (!rst_b)
		(edge_sel == MIC_EDGE_OFF) |=> !edge_pulse_q;
	endproperty
	a_off_quiet: assert property (p_off_quiet)
		else $error("edge reported while input disabled");

endmodule : mic_edge_detect

// >>> tb/mic_core_model.sv
// behavioural model of the core side: stack depth, sleep state, pops.
// assumes the controller's call and push pulses last one mclk cycle.
`timescale 1ns/1ps

module mic_core_model #(
	parameter int DEPTH = 2
)(
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_b,
	// from the controller
	input  wire logic       irq_call_q,
	input  wire logic       push_pc_q,
	// bench commands
	input  wire logic       sleep_cmd,
	input  wire logic       pop_cmd,
	input  wire logic       hold_full,
	// to the controller
	output logic            stack_full,
	output logic            core_asleep
);
	logic [3:0] depth_q;
	logic       asleep_q;

	// ****************************************************************
	// stack and sleep
	// ****************************************************************
	// only the return address is counted, nothing else is saved
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			depth_q <= 4'h0;
		end else if (push_pc_q && depth_q < DEPTH) begin
			depth_q <= depth_q + 4'h1;
		end else if (pop_cmd && depth_q != 4'h0) begin
			depth_q <= depth_q - 4'h1;
		end
	end

	// the call itself ends sleep; wake_q alone does not
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			asleep_q <= 1'b0;
		end else if (irq_call_q) begin
			asleep_q <= 1'b0;
		end else if (sleep_cmd) begin
			asleep_q <= 1'b1;
		end
	end

	assign stack_full  = hold_full || depth_q == DEPTH;
	assign core_asleep = asleep_q;
endmodule : mic_core_model

// >>> tb/tb_mic_intc.sv
// self-checking bench of the interrupt controller with a core model.
// assumes one-cycle wishbone answers and four-clock instruction ticks.
`timescale 1ns/1ps

module tb_mic_intc;
	import mic_pkg::*;
	logic        mclk, rst_b, wb_cyc, wb_stb, wb_we, ack, full, asleep;
	logic [3:0]  wb_adr, wb_sel;
	logic [31:0] wb_dat, rdat;
	logic        ext_pin, t0_ovf, t1_ovf, tb_ovf, call, push, wake;
	logic        sleep_cmd, pop_cmd, hold_full;
	logic [7:0]  vec;
	int          n_mismatch, check_count;
	logic [7:0]  vecs [4] = '{MIC_VEC_EXT, MIC_VEC_T0, MIC_VEC_T1, MIC_VEC_TB};

	mic_intc i_dut (.mclk(mclk), .rst_b(rst_b), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_ack_o(ack),
		.wb_dat_o(rdat), .ext_irq_pin(ext_pin), .timer0_ovf(t0_ovf),
		.timer1_ovf(t1_ovf), .timebase_ovf(tb_ovf), .stack_full(full),
		.core_asleep(asleep), .irq_call_q(call), .push_pc_q(push),
		.irq_vector_q(vec), .wake_q(wake));
	mic_core_model i_core (.mclk(mclk), .rst_b(rst_b), .irq_call_q(call),
		.push_pc_q(push), .sleep_cmd(sleep_cmd), .pop_cmd(pop_cmd),
		.hold_full(hold_full), .stack_full(full), .core_asleep(asleep));

	always #25 mclk = ~mclk;

	// ****************************************************************
	// compare, verdict, bus and event tasks
	// ****************************************************************
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk8

	task automatic chk1(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask : chk1

	task automatic give_verdict;
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : give_verdict

	// holds the request until ack is sampled high
	task automatic xfer(input logic w, input logic [3:0] a,
			input logic [7:0] d, output logic [7:0] r);
		int n;
		n = 0;
		@(posedge mclk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we  <= w;
		wb_adr <= a;
		wb_sel <= 4'h1;
		wb_dat <= {24'h000000, d};
		do begin
			@(posedge mclk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		chk1(ack, 1'b1);
		r = rdat[7:0];
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask : xfer

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [7:0] r;
		xfer(1'b1, a, d, r);
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		logic [7:0] r;
		xfer(1'b0, a, 8'h00, r);
		chk8(r, exp);
	endtask : rd

	task automatic fire(input int s);
		@(posedge mclk);
		ext_pin <= (s == 0);
		t0_ovf  <= (s == 1);
		t1_ovf  <= (s == 2);
		tb_ovf  <= (s == 3);
		@(posedge mclk);
		{ext_pin, t0_ovf, t1_ovf, tb_ovf} <= 4'h0;
	endtask : fire

	// counts calls over a window; push must come with each call
	task automatic wait_call(output logic [7:0] v, output int n);
		n = 0;
		v = 8'h00;
		repeat (40) begin
			@(posedge mclk);
			if (call === 1'b1) begin
				if (n == 0) v = vec;
				n++;
				chk1(push, 1'b1);
			end
		end
	endtask : wait_call

	task automatic ret;
		@(posedge mclk);
		pop_cmd <= 1'b1;
		@(posedge mclk);
		pop_cmd <= 1'b0;
	endtask : ret

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_regs;
		rd(MIC_OFS_PRIMARY, 8'h00);
		rd(MIC_OFS_SECOND, 8'h00);
		// global enable kept off while flags are set, else a call follows
		wr(MIC_OFS_PRIMARY, 8'hfe);
		rd(MIC_OFS_PRIMARY, 8'h7e);
		wr(MIC_OFS_SECOND, 8'hff);
		rd(MIC_OFS_SECOND, 8'h11);
		wr(MIC_OFS_SECOND, 8'h00);
		wr(MIC_OFS_PRIMARY, 8'h01);
		rd(MIC_OFS_PRIMARY, 8'h01);
		wr(4'h2, 8'hff);
		rd(4'h2, 8'h00);
		wr(MIC_OFS_PRIMARY, 8'h00);
	endtask : t_regs

	task automatic t_sources;
		logic [7:0] v, en;
		int n;
		wr(MIC_OFS_SYSCTL, 8'h40);
		for (int s = 0; s < 4; s++) begin
			en = (s == 3) ? 8'h00 : 8'h01 << (s + 1);
			wr(MIC_OFS_PRIMARY, en | 8'h01);
			wr(MIC_OFS_SECOND, (s == 3) ? 8'h01 : 8'h00);
			fire(s);
			wait_call(v, n);
			chk8(v, vecs[s]);
			chk1(n == 1, 1'b1);
			rd(MIC_OFS_PRIMARY, en);
			rd(MIC_OFS_SECOND, (s == 3) ? 8'h01 : 8'h00);
			ret;
		end
	endtask : t_sources

	task automatic t_priority;
		logic [7:0] v, fl;
		int n;
		wr(MIC_OFS_PRIMARY, 8'h0e);
		for (int s = 0; s < 4; s++) fire(s);
		rd(MIC_OFS_PRIMARY, 8'h7e);
		rd(MIC_OFS_SECOND, 8'h11);
		fl = 8'h70;
		for (int s = 0; s < 4; s++) begin
			wr(MIC_OFS_PRIMARY, fl | 8'h0f);
			wait_call(v, n);
			chk8(v, vecs[s]);
			chk1(n == 1, 1'b1);
			if (s < 3) fl[s + 4] = 1'b0;
			ret;
		end
		rd(MIC_OFS_PRIMARY, 8'h0e);
		wr(MIC_OFS_PRIMARY, 8'h00);
		wr(MIC_OFS_SECOND, 8'h00);
	endtask : t_priority

	task automatic t_mask;
		logic [7:0] v;
		int n;
		wr(MIC_OFS_PRIMARY, 8'h01);
		fire(2);
		wait_call(v, n);
		chk1(n == 0, 1'b1);
		rd(MIC_OFS_PRIMARY, 8'h41);
		wr(MIC_OFS_PRIMARY, 8'h01);
		rd(MIC_OFS_PRIMARY, 8'h01);
		wr(MIC_OFS_PRIMARY, 8'h00);
	endtask : t_mask

	task automatic t_stack;
		logic [7:0] v;
		int n;
		hold_full <= 1'b1;
		wr(MIC_OFS_PRIMARY, 8'h05);
		fire(1);
		wait_call(v, n);
		chk1(n == 0, 1'b1);
		rd(MIC_OFS_PRIMARY, 8'h25);
		rd(MIC_OFS_STATUS, 8'h1e);
		hold_full <= 1'b0;
		wait_call(v, n);
		chk8(v, MIC_VEC_T0);
		rd(MIC_OFS_PRIMARY, 8'h04);
		ret;
		wr(MIC_OFS_PRIMARY, 8'h00);
	endtask : t_stack

	task automatic t_wake;
		logic [7:0] v;
		int n;
		@(posedge mclk);
		sleep_cmd <= 1'b1;
		@(posedge mclk);
		sleep_cmd <= 1'b0;
		wr(MIC_OFS_SECOND, 8'h01);
		fire(3);
		repeat (4) @(posedge mclk);
		chk1(wake, 1'b1);
		chk1(asleep, 1'b1);
		wr(MIC_OFS_PRIMARY, 8'h01);
		wait_call(v, n);
		chk8(v, MIC_VEC_TB);
		chk1(asleep, 1'b0);
		chk1(wake, 1'b0);
		ret;
		wr(MIC_OFS_SECOND, 8'h00);
	endtask : t_wake

	// pin toggles with interrupts off; only the flag is watched
	task automatic t_edges;
		for (int m = 0; m < 4; m++) begin
			wr(MIC_OFS_SYSCTL, 8'(m << 6));
			@(posedge mclk);
			ext_pin <= 1'b1;
			repeat (3) @(posedge mclk);
			rd(MIC_OFS_PRIMARY, (m % 2 == 1) ? 8'h10 : 8'h00);
			wr(MIC_OFS_PRIMARY, 8'h00);
			@(posedge mclk);
			ext_pin <= 1'b0;
			repeat (3) @(posedge mclk);
			rd(MIC_OFS_PRIMARY, (m >= 2) ? 8'h10 : 8'h00);
			wr(MIC_OFS_PRIMARY, 8'h00);
		end
	endtask : t_edges

	// ****************************************************************
	// main sequence and watchdog
	// ****************************************************************
	initial begin
		{mclk, rst_b, wb_cyc, wb_stb, wb_we, wb_adr, wb_sel} = '0;
		{wb_dat, ext_pin, t0_ovf, t1_ovf, tb_ovf} = '0;
		{sleep_cmd, pop_cmd, hold_full} = '0;
		n_mismatch = 0;
		check_count = 0;
		repeat (5) @(posedge mclk);
		rst_b <= 1'b1;
		t_regs;
		t_sources;
		t_priority;
		t_mask;
		t_stack;
		t_wake;
		t_edges;
		give_verdict;
	end

	// the whole run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge mclk);
		n_mismatch++;
		give_verdict;
	end
endmodule : tb_mic_intc
